// >>> hw/wpsr_pkg.sv
package wpsr_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned TICK_MS       = 1;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned DELAY_MAX_MS  = 127;
  localparam int unsigned DELAY_W       = 7;
  localparam int unsigned WDT_CODE_W    = 4;
  localparam int unsigned WDT_CNT_W     = 16;
  localparam int unsigned COLD_DLY_MS   = 100;
  localparam logic [7:0]  PWROFF_KEY    = 8'h5A;

  // ---------------------------------------------------------------
  // Pin functions and modes
  // ---------------------------------------------------------------
  localparam logic [2:0] PIN4_FN_KICK   = 3'h3;

  typedef enum logic [1:0] {
    BUCK_DIS_FORCED_PWM_MODE, BUCK_DIS_AUTO, BUCK_DIS_RES_RAMP, BUCK_DIS_RES_ONLY
  } wpsr_buck_dis_type;

  typedef enum logic {
    LIN_DIS_RES_RAMP, LIN_DIS_RES_ONLY
  } wpsr_lin_dis_type;

  typedef enum logic [3:0] {
    ST_STANDBY, ST_POWERUP, ST_ACTIVE, ST_POWERDOWN, ST_SLEEP,
    ST_WAKE, ST_IORESET, ST_FAULT, ST_COLDWAIT
  } wpsr_state_type;

  // Watchdog control bundle
  typedef struct packed {
    logic                  enable;
    logic                  pdSelect;
    logic                  rstSelect;
    logic [2:0]            pin4Func;
    logic [WDT_CODE_W-1:0] code;
  } wpsr_wdt_cfg_type;

  typedef struct packed {
    logic latched;
    logic live;
  } wpsr_wdt_err_type;

endpackage : wpsr_pkg

// >>> hw/wpsr_sequencer.sv
`timescale 1ns/100ps
module wpsr_sequencer
  import wpsr_pkg::*;
#(
  parameter int unsigned RAILS      = 9,
  parameter int unsigned RESET_PINS = 2,
  parameter int unsigned TICK_DIV   = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       srst,
  // Pins
  input  wire logic                       powerRequestIn,
  input  wire logic                       watchdogKickInN,
  output logic                            intOutN,
  output logic [RESET_PINS-1:0]           resetOut,
  output logic                            railGoodOutput,
  // Configuration
  input  wire wpsr_wdt_cfg_type           wdtCfg,
  input  wire logic                       wdtIntMask,
  input  wire logic [RAILS*DELAY_W-1:0]   railOnDelay,
  input  wire logic [RAILS*DELAY_W-1:0]   railOffDelay,
  input  wire logic [RESET_PINS*DELAY_W-1:0] rstOnDelay,
  input  wire logic [RESET_PINS*DELAY_W-1:0] rstOffDelay,
  input  wire logic [RAILS-1:0]           railFault,
  input  wire logic [RAILS-1:0]           railFaultShutdown,
  input  wire logic [RAILS-1:0]           railSoftStartDone,
  input  wire logic                       sleepRequest,
  input  wire wpsr_buck_dis_type          buckDisMode,
  input  wire wpsr_lin_dis_type           linDisMode,
  // Software strobes
  input  wire logic                       keyWrite,
  input  wire logic [7:0]                 keyValue,
  input  wire logic                       warmWrite,
  input  wire logic                       coldWrite,
  input  wire logic                       errClearWrite,
  // Status and rail control
  output wpsr_wdt_err_type                wdtErr,
  output logic                            warmBit,
  output logic                            coldBit,
  output logic [RAILS-1:0]                railEnable,
  output logic                            dischargeEnable,
  output logic                            dischargeRamp,
  output logic                            dischargeFpwm,
  output wpsr_state_type                  seqState
);

  // ---------------------------------------------------------------
  // Input edges
  // ---------------------------------------------------------------
  logic kickQ, pwrQ;
  wire  wdtOn     = wdtCfg.enable && (wdtCfg.pin4Func == PIN4_FN_KICK);
  wire  kickFall  = kickQ && !watchdogKickInN && wdtOn;
  wire  pwrRise   = powerRequestIn && !pwrQ;
  wire  pwrFall   = !powerRequestIn && pwrQ;

  // ---------------------------------------------------------------
  // Millisecond tick and timeout table
  // ---------------------------------------------------------------
  logic [23:0] divQ;
  wire  tick = (divQ == 24'(TICK_DIV - 1));
  logic [WDT_CNT_W-1:0] wdtLimit;
  always_comb begin
    wdtLimit = WDT_CNT_W'(16'h0040) << wdtCfg.code[3:1];
    if (wdtCfg.code[0]) begin
      wdtLimit = wdtLimit + (wdtLimit >> 1);
    end
  end

  // ---------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------
  wpsr_state_type stateQ, stateD;
  logic [WDT_CNT_W-1:0] wdtCntQ;
  logic wdtRunQ, clrOkQ;
  wire  pdMode    = wdtCfg.pdSelect;
  wire  rstMode   = wdtCfg.rstSelect && !wdtCfg.pdSelect;
  wire  wdtExpire = wdtOn && wdtRunQ && tick && (wdtCntQ >= wdtLimit - 1'b1);
  wire  inStandby = (stateQ == ST_STANDBY);
  wire  clearOk   = pdMode ? (stateQ == ST_FAULT) : clrOkQ;
  wire  errClear  = errClearWrite && clearOk && wdtErr.latched;

  always_ff @(posedge clk) begin
    if (srst) begin
      kickQ   <= 1'b1;
      pwrQ    <= 1'b0;
      divQ    <= '0;
      wdtCntQ <= '0;
      wdtRunQ <= 1'b0;
      clrOkQ  <= 1'b0;
      wdtErr  <= '0;
    end else begin
      kickQ <= watchdogKickInN;
      pwrQ  <= powerRequestIn;
      // Tick phase restarts with each state so delays count from entry
      divQ  <= (tick || stateD != stateQ) ? '0 : divQ + 1'b1;
      if (stateD == ST_STANDBY) begin
        wdtRunQ <= 1'b0;
        wdtCntQ <= '0;
      end else if (stateQ == ST_STANDBY && stateD == ST_POWERUP) begin
        wdtRunQ <= 1'b1;
        wdtCntQ <= '0;
      end else if (wdtExpire) begin
        wdtRunQ <= 1'b0;
      end else if (kickFall && !(pdMode && wdtErr.latched)) begin
        wdtRunQ <= 1'b1;
        wdtCntQ <= '0;
      end else if (errClear && pdMode) begin
        wdtRunQ <= 1'b1;
        wdtCntQ <= '0;
      end else if (wdtRunQ && tick) begin
        wdtCntQ <= wdtCntQ + 1'b1;
      end
      // Kick or release opens the clear window; expiry closes it
      if (wdtExpire) begin
        clrOkQ <= 1'b0;
      end else if (kickFall || pwrFall) begin
        clrOkQ <= 1'b1;
      end
      // Set beats clear
      if (wdtExpire) begin
        wdtErr <= '{latched: 1'b1, live: 1'b1};
      end else if (errClear) begin
        wdtErr <= '0;
      end else if (kickFall && rstMode) begin
        wdtErr.live <= 1'b0;
      end
    end
  end
  assign intOutN = !(wdtErr.latched && !wdtIntMask);

  // ---------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------
  logic [DELAY_W:0] msQ;
  logic [DELAY_W:0] coldQ;
  logic keyHit, anyShut, offDone, offToFault, warmQ, coldQ2;
  logic railHoldQ;
  assign keyHit  = keyWrite && (keyValue == PWROFF_KEY);
  assign anyShut = |(railFault & railSoftStartDone & railFaultShutdown);
  assign offDone = tick && (msQ >= (DELAY_W+1)'(DELAY_MAX_MS));

  always_comb begin
    stateD = stateQ;
    unique case (stateQ)
      ST_STANDBY: begin
        if (coldQ2 && coldQ >= (DELAY_W+1)'(COLD_DLY_MS)) begin
          stateD = ST_POWERUP;
        end else if (pwrRise && !coldQ2) begin
          stateD = ST_POWERUP;
        end
      end
      ST_POWERUP:   stateD = ST_ACTIVE;
      ST_ACTIVE: begin
        if (anyShut || (wdtExpire && pdMode)) begin
          stateD = ST_POWERDOWN;
        end else if (wdtExpire && rstMode) begin
          stateD = ST_IORESET;
        end else if (keyHit || coldWrite || pwrFall) begin
          stateD = ST_POWERDOWN;
        end else if (warmWrite) begin
          stateD = ST_IORESET;
        end else if (sleepRequest) begin
          stateD = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wdtExpire || !sleepRequest) begin
          stateD = ST_WAKE;
        end
      end
      ST_WAKE:      stateD = ST_ACTIVE;
      ST_IORESET:   stateD = ST_ACTIVE;
      ST_POWERDOWN: begin
        if (offDone) begin
          stateD = offToFault ? ST_FAULT : ST_STANDBY;
        end
      end
      ST_FAULT: begin
        if (errClear) begin
          stateD = ST_POWERUP;
        end
      end
      default:      stateD = ST_STANDBY;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stateQ     <= ST_STANDBY;
      msQ        <= '0;
      coldQ      <= '0;
      offToFault <= 1'b0;
      warmQ      <= 1'b0;
      coldQ2     <= 1'b0;
      railHoldQ  <= 1'b0;
    end else begin
      stateQ <= stateD;
      // Rails stay up through warm reset, sleep and their return
      if (stateD == ST_STANDBY || stateD == ST_POWERDOWN) begin
        railHoldQ <= 1'b0;
      end else if (stateQ == ST_ACTIVE && stateD != ST_ACTIVE) begin
        railHoldQ <= 1'b1;
      end
      // Time base restarts on entry to every state, including active and powerdown
      if (stateD != stateQ) begin
        msQ <= '0;
      end else if (tick && msQ <= (DELAY_W+1)'(DELAY_MAX_MS)) begin
        msQ <= msQ + 1'b1;
      end
      if (stateQ == ST_STANDBY && coldQ2 && tick) begin
        coldQ <= coldQ + 1'b1;
      end else if (stateQ != ST_STANDBY) begin
        coldQ <= '0;
      end
      if (stateQ == ST_ACTIVE && stateD == ST_POWERDOWN) begin
        offToFault <= anyShut || wdtExpire;
      end
      // Reset bits clear once the sequence completes
      if (warmWrite) begin
        warmQ <= 1'b1;
      end else if (stateQ == ST_ACTIVE && msQ > (DELAY_W+1)'(DELAY_MAX_MS)) begin
        warmQ <= 1'b0;
      end
      if (coldWrite) begin
        coldQ2 <= 1'b1;
      end else if (stateQ == ST_ACTIVE && msQ > (DELAY_W+1)'(DELAY_MAX_MS)) begin
        coldQ2 <= 1'b0;
      end
    end
  end
  assign warmBit  = warmQ;
  assign coldBit  = coldQ2;
  assign seqState = stateQ;

  // ---------------------------------------------------------------
  // Rails and reset pins
  // ---------------------------------------------------------------
  wire onPhase  = (stateQ == ST_ACTIVE) || (stateQ == ST_SLEEP) ||
                  (stateQ == ST_WAKE) ||
                  (stateQ == ST_IORESET && railHoldQ);
  wire offPhase = (stateQ == ST_POWERDOWN);
  for (genvar r = 0; r < RAILS; r++) begin : gRail
    wire [DELAY_W:0] onD  = {1'b0, railOnDelay[r*DELAY_W +: DELAY_W]};
    wire [DELAY_W:0] offD = {1'b0, railOffDelay[r*DELAY_W +: DELAY_W]};
    assign railEnable[r] = (onPhase && (msQ >= onD || railHoldQ)) ||
                           (offPhase && msQ < offD);
  end
  for (genvar p = 0; p < RESET_PINS; p++) begin : gRst
    wire [DELAY_W:0] onD  = {1'b0, rstOnDelay[p*DELAY_W +: DELAY_W]};
    wire [DELAY_W:0] offD = {1'b0, rstOffDelay[p*DELAY_W +: DELAY_W]};
    assign resetOut[p] = !((stateQ == ST_ACTIVE && msQ >= onD) ||
                           stateQ == ST_SLEEP || stateQ == ST_WAKE ||
                           (offPhase && msQ < offD));
  end
  assign railGoodOutput = onPhase &&
                          !(|(railFault & railSoftStartDone));

  // ---------------------------------------------------------------
  // Discharge
  // ---------------------------------------------------------------
  assign dischargeEnable = (stateQ == ST_POWERDOWN) ||
                           (stateQ == ST_ACTIVE);
  assign dischargeRamp   = (buckDisMode != BUCK_DIS_RES_ONLY) ||
                           (linDisMode == LIN_DIS_RES_RAMP);
  assign dischargeFpwm   = (buckDisMode == BUCK_DIS_FORCED_PWM_MODE);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_wdt_standby_off: assert property (@(posedge clk) disable iff (srst)
    stateQ == ST_STANDBY |=> !wdtRunQ || stateQ != ST_STANDBY)
    else $error("watchdog running in standby");
  chk_expire_flags: assert property (@(posedge clk) disable iff (srst)
    wdtExpire |=> wdtErr.latched && wdtErr.live)
    else $error("expiry did not set flags");
  chk_int_low: assert property (@(posedge clk) disable iff (srst)
    wdtErr.latched && !wdtIntMask |-> !intOutN)
    else $error("interrupt not driven low");
  chk_sleep_wake: assert property (@(posedge clk) disable iff (srst)
    stateQ == ST_SLEEP && wdtExpire |=> stateQ == ST_WAKE ##1
    stateQ == ST_ACTIVE)
    else $error("sleep expiry did not wake");
  chk_rst_halt: assert property (@(posedge clk) disable iff (srst)
    wdtExpire && rstMode |=> !wdtRunQ)
    else $error("counter not halted");
  chk_pd_priority: assert property (@(posedge clk) disable iff (srst)
    stateQ == ST_ACTIVE && wdtExpire && pdMode |=> stateQ == ST_POWERDOWN)
    else $error("power-down not taken");
  chk_pd_clear_block: assert property (@(posedge clk) disable iff (srst)
    pdMode && wdtErr.latched && stateQ != ST_FAULT && !wdtExpire
    |=> wdtErr.latched)
    else $error("error cleared before fault");
  chk_start_pwr: assert property (@(posedge clk) disable iff (srst)
    stateQ == ST_STANDBY && pwrRise && !coldQ2 |=> stateQ == ST_POWERUP
    ##1 stateQ == ST_ACTIVE)
    else $error("power request ignored");
  chk_discharge_gate: assert property (@(posedge clk) disable iff (srst)
    stateQ == ST_POWERUP || stateQ == ST_IORESET |-> !dischargeEnable)
    else $error("discharge during startup");
  chk_kick_ignored: assert property (@(posedge clk) disable iff (srst)
    !wdtOn |-> !kickFall)
    else $error("kick accepted while off");
  chk_warm_rails: assert property (@(posedge clk) disable iff (srst)
    stateQ == ST_IORESET && railHoldQ |-> &railEnable)
    else $error("rails dropped in warm reset");
  chk_cold_standby: assert property (@(posedge clk) disable iff (srst)
    stateQ == ST_POWERDOWN && offDone && !offToFault |=> stateQ == ST_STANDBY)
    else $error("power-off did not reach standby");

endmodule : wpsr_sequencer

// >>> dv/wpsr_host_model.sv
`timescale 1ns/100ps
module wpsr_host_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Bench commands
  input  wire logic        powerOn,
  input  wire logic        kickOn,
  input  wire logic [15:0] kickGap,
  // Device pins
  output logic             powerRequestIn,
  output logic             watchdogKickInN
);
  logic [15:0] gapQ;

  // Gap saturates so an idle host never kicks by wrap-around
  always_ff @(posedge clk) begin
    if (srst) begin
      gapQ            <= 16'h0000;
      watchdogKickInN <= 1'b1;
      powerRequestIn  <= 1'b0;
    end else begin
      powerRequestIn <= powerOn;
      if (kickOn && gapQ >= kickGap) begin
        gapQ            <= 16'h0000;
        watchdogKickInN <= 1'b0;
      end else begin
        gapQ            <= (gapQ == 16'hffff) ? gapQ : gapQ + 16'h0001;
        watchdogKickInN <= (gapQ >= 16'h0001);
      end
    end
  end
endmodule : wpsr_host_model

// >>> dv/wpsr_sequencer_test.sv
`timescale 1ns/100ps
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin failures++; $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module wpsr_sequencer_test;
  import wpsr_pkg::*;
  localparam int T  = 4;
  localparam int NR = 3;
  localparam int NP = 2;
  // ----
  // Signals
  // ----
  logic clk = 1'b0;
  logic srst, powerOn, kickOn, powerRequestIn, watchdogKickInN, intOutN;
  logic wdtIntMask, railGoodOutput, warmBit, coldBit, sleepReq;
  logic dischargeEnable, dischargeRamp, dischargeFpwm;
  logic [15:0] kickGap;
  logic [3:0] strb;
  logic [7:0] keyValue;
  logic [NR-1:0] railFault, railEnable;
  logic [NP-1:0] resetOut;
  logic [NR*7-1:0] railOnDelay, railOffDelay;
  logic [NP*7-1:0] rstOnDelay, rstOffDelay;
  wpsr_wdt_cfg_type wdtCfg;
  wpsr_wdt_err_type wdtErr;
  wpsr_buck_dis_type buckDisMode;
  wpsr_lin_dis_type linDisMode;
  wpsr_state_type seqState;
  logic [31:0] seed = 32'h0000_96ab;
  int failures  = 0;
  int numChecks = 0;

  always #50 clk = ~clk;

  wpsr_host_model u_host (.clk(clk), .srst(srst), .powerOn(powerOn),
    .kickOn(kickOn), .kickGap(kickGap), .powerRequestIn(powerRequestIn),
    .watchdogKickInN(watchdogKickInN));

  wpsr_sequencer #(.RAILS(NR), .RESET_PINS(NP), .TICK_DIV(T)) u_dut (
    .clk(clk), .srst(srst), .powerRequestIn(powerRequestIn),
    .watchdogKickInN(watchdogKickInN), .intOutN(intOutN),
    .resetOut(resetOut), .railGoodOutput(railGoodOutput), .wdtCfg(wdtCfg),
    .wdtIntMask(wdtIntMask), .railOnDelay(railOnDelay),
    .railOffDelay(railOffDelay), .rstOnDelay(rstOnDelay),
    .rstOffDelay(rstOffDelay), .railFault(railFault),
    .railFaultShutdown({NR{1'b0}}), .railSoftStartDone({NR{1'b1}}),
    .sleepRequest(sleepReq), .buckDisMode(buckDisMode), .linDisMode(linDisMode),
    .keyWrite(strb[3]), .keyValue(keyValue), .warmWrite(strb[0]),
    .coldWrite(strb[1]), .errClearWrite(strb[2]), .wdtErr(wdtErr),
    .warmBit(warmBit), .coldBit(coldBit), .railEnable(railEnable),
    .dischargeEnable(dischargeEnable), .dischargeRamp(dischargeRamp),
    .dischargeFpwm(dischargeFpwm), .seqState(seqState));

  // ----
  // Helpers
  // ----
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  function automatic logic due(input int m, input logic [6:0] d);
    return m >= int'(d);
  endfunction : due

  task automatic print_verdict();
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  task automatic fin_if(input logic bad);
    if (bad) begin
      failures++;
      print_verdict();
    end
  endtask : fin_if

  // One strobe at a time; warm and cold never share a write
  task automatic pulse(input logic [3:0] m);
    @(posedge clk) strb <= m;
    @(posedge clk) strb <= 4'h0;
    @(negedge clk);
  endtask : pulse

  task automatic wait_st(input wpsr_state_type s, input int lim);
    for (int i = 0; i < lim && seqState !== s; i++) @(negedge clk);
    fin_if(seqState !== s);
  endtask : wait_st

  task automatic wait_err();
    for (int i = 0; i < 500 && wdtErr.latched !== 1'b1; i++) @(negedge clk);
    fin_if(wdtErr.latched !== 1'b1);
  endtask : wait_err

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // Discharge must stay off before the sequencer is up
  always @(negedge clk) begin
    if (!srst && (seqState === ST_STANDBY || seqState === ST_POWERUP)) begin
      `CHK(dischargeEnable, 1'b0)
    end
  end

  // ----
  // Main sequence
  // ----
  initial begin
    srst = 1'b1; powerOn = 1'b0; kickOn = 1'b0; kickGap = 16'h0064;
    strb = 4'h0; keyValue = 8'h00; railFault = '0; wdtIntMask = 1'b0;
    sleepReq = 1'b0;
    seed = nxt(seed);
    wdtCfg = '{1'b1, 1'b0, 1'b1, PIN4_FN_KICK, {3'h0, seed[0]}};
    buckDisMode = wpsr_buck_dis_type'(seed[2:1]);
    linDisMode = wpsr_lin_dis_type'(seed[3]);
    for (int r = 0; r < NR; r++) begin
      seed = nxt(seed);
      railOnDelay[r*7+:7] = {3'h0, seed[3:0]} + 7'h01;
      railOffDelay[r*7+:7] = {3'h0, seed[7:4]};
      if (r < NP) rstOnDelay[r*7+:7] = {3'h0, seed[11:8]};
      if (r < NP) rstOffDelay[r*7+:7] = {3'h0, seed[15:12]};
    end
    railOnDelay[6:0] = 7'h7f;
    rstOnDelay[6:0] = 7'h00;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    idle(1);
    `CHK(seqState, ST_STANDBY)
    `CHK(resetOut, {NP{1'b1}})
    `CHK(railEnable, {NR{1'b0}})
    `CHK(intOutN, 1'b1)
    idle(500);
    `CHK(wdtErr, 2'b00)
    $display("test reset done");
    @(posedge clk) begin powerOn <= 1'b1; kickOn <= 1'b1; end
    wait_st(ST_ACTIVE, 10);
    idle(T / 2);
    for (int m = 0; m < 130; m++) begin
      for (int r = 0; r < NR; r++) `CHK(railEnable[r], due(m, railOnDelay[r*7+:7]))
      for (int p = 0; p < NP; p++) `CHK(resetOut[p], !due(m, rstOnDelay[p*7+:7]))
      idle(T);
    end
    `CHK(wdtErr, 2'b00)
    `CHK(railGoodOutput, 1'b1)
    @(posedge clk) railFault <= 3'h2;
    idle(3);
    `CHK(railGoodOutput, 1'b0)
    @(posedge clk) railFault <= '0;
    $display("test powerup done");
    @(posedge clk) kickOn <= 1'b0;
    idle(120);
    `CHK(wdtErr.latched, 1'b0)
    wait_err();
    `CHK(wdtErr, 2'b11)
    `CHK(intOutN, 1'b0)
    `CHK(resetOut, {NP{1'b1}})
    pulse(4'h4);
    `CHK(wdtErr.latched, 1'b1)
    idle(20 * T);
    `CHK(resetOut, {NP{1'b0}})
    @(posedge clk) kickOn <= 1'b1;
    @(posedge clk) kickOn <= 1'b0;
    idle(8);
    pulse(4'h4);
    `CHK(wdtErr, 2'b00)
    `CHK(intOutN, 1'b1)
    @(posedge clk) kickOn <= 1'b1;
    $display("test reset-only done");
    pulse(4'h1);
    `CHK(warmBit, 1'b1)
    `CHK(resetOut, {NP{1'b1}})
    `CHK(railEnable, {NR{1'b1}})
    idle(140 * T);
    `CHK(warmBit, 1'b0)
    `CHK(resetOut, {NP{1'b0}})
    pulse(4'h2);
    `CHK(coldBit, 1'b1)
    wait_st(ST_STANDBY, 700);
    `CHK(railEnable, {NR{1'b0}})
    wait_st(ST_ACTIVE, 500);
    idle(140 * T);
    `CHK(coldBit, 1'b0)
    `CHK(resetOut, {NP{1'b0}})
    $display("test warm-cold done");
    seed = nxt(seed);
    @(posedge clk) keyValue <= (seed[7:0] == PWROFF_KEY) ? 8'h00 : seed[7:0];
    pulse(4'h8);
    idle(3);
    `CHK(seqState, ST_ACTIVE)
    @(posedge clk) keyValue <= PWROFF_KEY;
    pulse(4'h8);
    wait_st(ST_POWERDOWN, 3);
    wait_st(ST_STANDBY, 700);
    @(posedge clk) kickOn <= 1'b0;
    idle(500);
    `CHK(wdtErr, 2'b00)
    @(posedge clk) powerOn <= 1'b0;
    idle(3);
    @(posedge clk) powerOn <= 1'b1;
    wait_st(ST_ACTIVE, 10);
    $display("test key done");
    @(posedge clk) sleepReq <= 1'b1;
    wait_st(ST_SLEEP, 5);
    wait_err();
    `CHK(seqState, ST_WAKE)
    idle(1);
    `CHK(seqState, ST_ACTIVE)
    @(posedge clk) begin sleepReq <= 1'b0; kickOn <= 1'b1; end
    @(posedge clk) kickOn <= 1'b0;
    idle(8);
    pulse(4'h4);
    `CHK(wdtErr, 2'b00)
    $display("test sleep done");
    @(posedge clk) begin wdtCfg.pdSelect <= 1'b1; wdtIntMask <= 1'b1; end
    wait_err();
    `CHK(intOutN, 1'b1)
    wait_st(ST_POWERDOWN, 3);
    pulse(4'h4);
    `CHK(wdtErr.latched, 1'b1)
    wait_st(ST_FAULT, 700);
    `CHK(railEnable, {NR{1'b0}})
    `CHK(resetOut, {NP{1'b1}})
    pulse(4'h4);
    `CHK(wdtErr, 2'b00)
    wait_st(ST_ACTIVE, 5);
    $display("test power-down done");
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) begin
        wdtCfg.enable <= k[0];
        wdtCfg.pin4Func <= (k == 1) ? 3'h0 : PIN4_FN_KICK;
        kickOn <= k[0];
      end
      idle(500);
      `CHK(wdtErr, 2'b00)
    end
    $display("test disabled done");
    print_verdict();
  end
endmodule : wpsr_sequencer_test
